/* File: hdl/tpfg_generator.sv */
module tpfg_generator #(
    parameter int NCLS = tpfg_pkg::NUM_CLASS,
    parameter int QW   = tpfg_pkg::QUANTA_W,
    parameter int TW   = tpfg_pkg::TIMER_W
) (
    input  wire logic                pclk_unused_guard,
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [NCLS-1:0]     pause_request_lines,
    input  wire logic [NCLS-1:0][QW-1:0] pause_quanta_value,
    input  wire logic [NCLS-1:0][TW-1:0] pause_refresh_interval,
    input  wire logic                pause_resend_pulse,
    input  wire logic                pause_frame_ready,
    output logic                     pause_frame_valid,
    output logic                     pause_frame_global,
    output logic [tpfg_pkg::CLASS_W-1:0] pause_frame_class,
    output logic [QW-1:0]            pause_frame_quanta,
    output logic [NCLS-1:0]          pause_sent_status,
    output logic [NCLS-1:0]          pause_pending
);

    tpfg_pkg::tpfg_state_t state;
    tpfg_pkg::tpfg_state_t next_state;

    logic [NCLS-1:0] req_prev;
    logic [NCLS-1:0] req_rise;
    logic [NCLS-1:0] expire;
    logic [NCLS-1:0] sent_onehot;
    logic [NCLS-1:0] restart;
    logic [NCLS-1:0] next_pending;
    logic [NCLS-1:0] next_status;
    logic [tpfg_pkg::CLASS_W-1:0] pick;
    logic                         pick_any;
    logic [tpfg_pkg::CLASS_W-1:0] next_class;
    logic                         next_global;
    logic [QW-1:0]                next_quanta;
    logic [NCLS-1:0]              next_req_prev;
    logic [NCLS-1:0]              rise_due;
    logic [NCLS-1:0]              refresh_due;
    logic [NCLS-1:0]              resend_due;

    assign req_rise = pause_request_lines & ~req_prev;
    assign restart  = req_rise | sent_onehot
                    | {NCLS{pause_resend_pulse}};

    // per-class refresh counters
    for (genvar g = 0; g < NCLS; g++) begin : g_timer
        tpfg_refresh_timer #(
            .W (TW)
        ) u_timer (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .restart  (restart[g]),
            .active   (pause_request_lines[g]),
            .interval (pause_refresh_interval[g]),
            .expire   (expire[g])
        );
    end

    // global class wins, then lowest priority index; fixed order keeps
    // the global frame from being starved by busy priorities
    always_comb begin
        pick     = tpfg_pkg::CLASS_RST;
        pick_any = 1'b0;
        for (int i = NCLS - 1; i >= 0; i--) begin
            if (pause_pending[i] && (i != tpfg_pkg::GLOBAL_BIT)) begin
                pick     = tpfg_pkg::CLASS_W'(i);
                pick_any = 1'b1;
            end
        end
        if (pause_pending[tpfg_pkg::GLOBAL_BIT]) begin
            pick     = tpfg_pkg::CLASS_W'(tpfg_pkg::GLOBAL_BIT);
            pick_any = 1'b1;
        end
    end

    assign pause_frame_valid = (state == tpfg_pkg::TPFG_OFFER);

    always_comb begin
        sent_onehot = '0;
        if (pause_frame_valid && pause_frame_ready) begin
            sent_onehot[pause_frame_class] = 1'b1;
        end
    end

    // request edge group: previous sample of the request lines
    always_comb begin
        next_req_prev = pause_request_lines;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // zero matches the idle level, so no false edge after reset
            req_prev <= tpfg_pkg::PEND_RST;
        end else begin
            req_prev <= next_req_prev;
        end
    end

    // reasons that make a class due for a frame
    always_comb begin
        rise_due    = req_rise;
        refresh_due = expire & pause_request_lines;
        resend_due  = {NCLS{pause_resend_pulse}}
                    & pause_request_lines;
    end

    // pending group
    always_comb begin
        // set wins over the clear made by a completed send
        next_pending = (pause_pending & ~sent_onehot)
                     | rise_due
                     | refresh_due
                     | resend_due;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pause_pending <= tpfg_pkg::PEND_RST;
        end else begin
            pause_pending <= next_pending;
        end
    end

    // offer state group: one frame outstanding at a time
    always_comb begin
        next_state = state;
        unique case (state)
            tpfg_pkg::TPFG_IDLE: begin
                if (pick_any) begin
                    next_state = tpfg_pkg::TPFG_OFFER;
                end
            end
            tpfg_pkg::TPFG_OFFER: begin
                // the mac raises ready only after the packet in flight ends
                if (pause_frame_ready) begin
                    next_state = tpfg_pkg::TPFG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= tpfg_pkg::TPFG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // frame descriptor group: held steady for the whole offer
    always_comb begin
        next_class  = pause_frame_class;
        next_global = pause_frame_global;
        next_quanta = pause_frame_quanta;
        if ((state == tpfg_pkg::TPFG_IDLE) && pick_any) begin
            next_class  = pick;
            // quanta sampled here; held steady until the offer is accepted
            next_quanta = pause_quanta_value[pick];
            next_global = (pick == tpfg_pkg::CLASS_W'(
                           tpfg_pkg::GLOBAL_BIT));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pause_frame_class  <= tpfg_pkg::CLASS_RST;
            pause_frame_global <= 1'b0;
            pause_frame_quanta <= tpfg_pkg::QUANTA_RST;
        end else begin
            pause_frame_class  <= next_class;
            pause_frame_global <= next_global;
            pause_frame_quanta <= next_quanta;
        end
    end

    // status group: one-cycle pulse per accepted frame
    always_comb begin
        next_status = '0;
        if ((state == tpfg_pkg::TPFG_OFFER) && pause_frame_ready) begin
            next_status = sent_onehot;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pause_sent_status <= tpfg_pkg::STATUS_RST;
        end else begin
            pause_sent_status <= next_status;
        end
    end

    // the spare input has no effect; it is left unread on purpose
    // so the port list stays stable for integrators

endmodule // tpfg_generator

/* File: hdl/tpfg_pkg.sv */
package tpfg_pkg;

    localparam int NUM_CLASS   = 9;
    localparam int GLOBAL_BIT  = 8;
    localparam int QUANTA_W    = 16;
    localparam int TIMER_W     = 16;
    localparam int CLASS_W     = 4;
    localparam int MIN_HOLD_CYC = 16;

    localparam logic [NUM_CLASS-1:0] PEND_RST   = 9'h000;
    localparam logic [NUM_CLASS-1:0] STATUS_RST = 9'h000;
    localparam logic [QUANTA_W-1:0]  QUANTA_RST = 16'h0000;
    localparam logic [CLASS_W-1:0]   CLASS_RST  = 4'h0;
    localparam logic [TIMER_W-1:0]   TIMER_ONE  = 16'h0001;
    localparam logic [TIMER_W-1:0]   TIMER_ZERO = 16'h0000;

    typedef enum logic [0:0] {
        TPFG_IDLE,
        TPFG_OFFER
    } tpfg_state_t;

endpackage

/* File: hdl/tpfg_refresh_timer.sv */
module tpfg_refresh_timer #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         restart,
    input  wire logic         active,
    input  wire logic [W-1:0] interval,
    output logic              expire
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_expire;

    // interval 0 disables periodic refresh rather than firing every cycle
    always_comb begin
        next_count  = count;
        next_expire = 1'b0;
        if (restart || !active) begin
            next_count = interval;
        end else if (interval != W'(0)) begin
            if (count <= W'(1)) begin
                next_count  = interval;
                next_expire = 1'b1;
            end else begin
                next_count = count - W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count  <= '0;
            expire <= 1'b0;
        end else begin
            count  <= next_count;
            expire <= next_expire;
        end
    end

endmodule // tpfg_refresh_timer

/* File: verification/tpfg_assertions.sv */
module tpfg_assertions #(
    parameter int NCLS = 9,
    parameter int QW   = 16
) (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic [NCLS-1:0]          pause_request_lines,
    input wire logic [NCLS-1:0][QW-1:0]  pause_quanta_value,
    input wire logic                     pause_resend_pulse,
    input wire logic                     pause_frame_ready,
    input wire logic                     pause_frame_valid,
    input wire logic                     pause_frame_global,
    input wire logic [tpfg_pkg::CLASS_W-1:0] pause_frame_class,
    input wire logic [QW-1:0]            pause_frame_quanta,
    input wire logic [NCLS-1:0]          pause_sent_status,
    input wire logic [NCLS-1:0]          pause_pending
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_acc;
        pause_frame_valid && pause_frame_ready;
    endsequence
    property p_pq;
        pause_frame_valid && !pause_frame_global |->
            pause_frame_quanta == pause_quanta_value[pause_frame_class];
    endproperty
    a_pq: assert property (p_pq) else $error("priority quanta wrong");
    property p_gq;
        pause_frame_valid && pause_frame_global |->
            pause_frame_quanta == pause_quanta_value[8];
    endproperty
    a_gq: assert property (p_gq) else $error("global quanta wrong");
    property p_gb;
        pause_frame_valid |-> pause_frame_global == (pause_frame_class == 8);
    endproperty
    a_gb: assert property (p_gb) else $error("global flag wrong");
    property p_st;
        s_acc |=> pause_sent_status == (9'h001 << $past(pause_frame_class));
    endproperty
    a_st: assert property (p_st) else $error("sent status wrong");
    property p_rq;
        (pause_request_lines & ~$past(pause_request_lines)) != 9'h000 |=>
            ($past(pause_request_lines) & ~$past(pause_request_lines, 2)
             & ~pause_pending) == 9'h000;
    endproperty
    a_rq: assert property (p_rq) else $error("request not queued");
    property p_rs;
        pause_resend_pulse |=>
            ($past(pause_request_lines) & ~pause_pending) == 9'h000;
    endproperty
    a_rs: assert property (p_rs) else $error("resend not queued");
    property p_hold;
        pause_frame_valid && !pause_frame_ready |=> pause_frame_valid
            && $stable(pause_frame_class) && $stable(pause_frame_quanta);
    endproperty
    a_hold: assert property (p_hold) else $error("offer dropped");
    property p_soon;
        pause_pending != 9'h000 |-> ##[0:2] pause_frame_valid;
    endproperty
    a_soon: assert property (p_soon) else $error("pending not sent");
endmodule // tpfg_assertions

/* File: verification/tpfg_mac_model.sv */
module tpfg_mac_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic pause_frame_valid,
    output logic     pause_frame_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ph = 1'b0;
    // slow mode accepts every other cycle to exercise held offers
    always_ff @(posedge core_clk) ph <= ~ph;
    assign pause_frame_ready = pause_frame_valid && (!slow || ph);
endmodule // tpfg_mac_model

/* File: verification/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, rst_n = 1'b0, rsnd = 1'b0, slow = 1'b0;
    logic [8:0] req = 9'h000, sts, pend;
    logic [8:0][15:0] qv, iv;
    logic vld, rdy, glb;
    logic [3:0] cls;
    logic [15:0] qo;
    int err_count = 0, num_checks = 0, cnt [9], sc [9];
    tpfg_generator i_dut (.pclk_unused_guard(1'b0), .core_clk, .rst_n,
        .pause_request_lines(req), .pause_quanta_value(qv),
        .pause_refresh_interval(iv), .pause_resend_pulse(rsnd),
        .pause_frame_ready(rdy), .pause_frame_valid(vld),
        .pause_frame_global(glb), .pause_frame_class(cls),
        .pause_frame_quanta(qo), .pause_sent_status(sts),
        .pause_pending(pend));
    tpfg_mac_model i_mac (.core_clk, .slow, .pause_frame_valid(vld),
        .pause_frame_ready(rdy));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (vld && rdy) begin
            cnt[cls]++;
            chk("quanta", qv[cls], qo);
            chk("global", 16'(cls == 4'h8), 16'(glb));
        end
        for (int k = 0; k < 9; k++) if (sts[k]) sc[k]++;
    end
    task automatic s_all(); // every class once, with a stalling acceptor
        slow = 1'b1;
        cnt = '{default: 0};
        sc = '{default: 0};
        req = 9'h1FF;
        wt(40);
        for (int k = 0; k < 9; k++) chk("frames", 16'h0001, 16'(cnt[k]));
        for (int k = 0; k < 9; k++) chk("status", 16'h0001, 16'(sc[k]));
        req = 9'h000;
        slow = 1'b0;
        wt(20);
    endtask
    task automatic s_refresh(); // short intervals on one priority and global
        iv[5] = 16'h0005;
        iv[8] = 16'h0005;
        cnt = '{default: 0};
        req = 9'h120;
        wt(60);
        chk("p5 resent", 16'h0001, 16'(cnt[5] >= 3));
        chk("gl resent", 16'h0001, 16'(cnt[8] >= 3));
        req = 9'h000;
        wt(20);
        cnt = '{default: 0};
        wt(30);
        chk("stopped", 16'h0000, 16'(cnt[5] + cnt[8]));
        iv = '0;
    endtask
    task automatic s_resend(); // one-cycle resend with a request held
        cnt = '{default: 0};
        req = 9'h001;
        wt(20);
        rsnd = 1'b1;
        wt(1);
        rsnd = 1'b0;
        wt(10);
        chk("resend", 16'h0002, 16'(cnt[0]));
        req = 9'h000;
        wt(20);
    endtask
    initial forever #12.5 core_clk = ~core_clk;
    initial begin
        iv = '0;
        for (int k = 0; k < 9; k++) qv[k] = 16'hA500 + 16'(k);
        wt(5);
        rst_n = 1'b1;
        wt(2);
        s_all();
        s_refresh();
        s_resend();
        close_out();
    end
    initial begin
        #(25 * 2000);
        err_count++;
        close_out();
    end
endmodule // tb
bind tpfg_generator tpfg_assertions #(.NCLS(NCLS), .QW(QW)) i_chk (.*);
